//--- src/ced_error_diag.sv
// Error counters, last-error diagnostic, bit timer and pin conditioning
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ced_error_diag (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [ced_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [ced_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [ced_pkg::DATA_W-1:0] regRdData,
  input  wire logic                      busRxPin,
  output logic                           busTxPin,
  input  wire logic                      bitTick,
  input  wire logic                      txActive,
  input  wire logic                      txBit,
  input  wire logic                      ackSlot,
  input  wire logic                      errFlagActive,
  input  wire logic [7:0]                rxFaultTally,
  input  wire logic [7:0]                txFaultTally,
  input  wire ced_pkg::ced_fseg_t        fieldSeg,
  input  wire ced_pkg::ced_fault_t       fault,
  input  wire logic                      xferDone,
  input  wire logic [3:0]                xferBuf,
  output logic                           rxBit,
  output logic                           ctrlEnable,
  output logic                           faultIrqPending,
  output logic      [15:0]               stampValue,
  output logic                           stampValid,
  output logic      [3:0]                stampBuf
);
  import ced_pkg::*;

  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] rdData_q;
  logic [7:0]        rxPrev_q;
  logic [7:0]        txPrev_q;
  logic              pend_q;
  ced_diag_t         diag_q;
  ced_fcode_t        curField_q;
  logic [5:0]        bitPos_q;
  logic [15:0]       tmr_q;
  logic [15:0]       stamp_q;
  logic              stampVld_q;
  logic [3:0]        stampBuf_q;
  logic              rxMeta_q;
  logic              rxS2_q;
  logic              rxS3_q;
  logic              rxLvl_q;
  logic              rxBit_q;
  logic              busTx_q;
  logic              busTx_d;
  logic              txLevel;
  logic              clrPend;
  logic              tallyMoved;
  logic              buf0Clear;

  wire logic enable = cfg_q[CFG_EN_BIT];
  wire logic txPol  = cfg_q[CFG_TXPOL_BIT];
  wire logic rxPol  = cfg_q[CFG_RXPOL_BIT];
  wire logic tsEn   = cfg_q[CFG_TSEN_BIT];

  // Configuration: only reset or a write changes it, so it survives
  // disable and power-down untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q <= CFG_RST;
    end else if (regWr && regAddr == OFF_CFG) begin
      cfg_q <= {{(DATA_W-CFG_USED){1'b0}}, regWrData[CFG_USED-1:0]};
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst || !regRd) begin
      rdData_q <= 16'h0000;
    end else begin
      unique case (regAddr)
        OFF_CFG:  rdData_q <= cfg_q;
        OFF_ECNT: rdData_q <= {rxFaultTally, txFaultTally};
        OFF_DIAG: rdData_q <= diag_q;
        OFF_TMR:  rdData_q <= tmr_q;
        OFF_IPND: rdData_q <= {15'h0000, pend_q};
        default:  rdData_q <= 16'h0000;
      endcase
    end
  end

  // Tally change detection; a change in the clearing cycle wins
  assign clrPend    = regWr && regAddr == OFF_ICLR && regWrData[ICLR_BIT];
  assign tallyMoved = rxFaultTally != rxPrev_q || txFaultTally != txPrev_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxPrev_q <= TALLY_RST;
      txPrev_q <= TALLY_RST;
      pend_q   <= 1'b0;
    end else begin
      rxPrev_q <= rxFaultTally;
      txPrev_q <= txFaultTally;
      if (tallyMoved) begin
        pend_q <= 1'b1;
      end else if (clrPend) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Receive pin: three flops, a change counts once stages two and
  // three agree, which also rejects single-cycle glitches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxMeta_q <= RECESSIVE;
      rxS2_q   <= RECESSIVE;
      rxS3_q   <= RECESSIVE;
      rxLvl_q  <= RECESSIVE;
      rxBit_q  <= RECESSIVE;
    end else begin
      rxMeta_q <= busRxPin;
      rxS2_q   <= rxMeta_q;
      rxS3_q   <= rxS2_q;
      if (rxS2_q == rxS3_q) begin
        rxLvl_q <= rxS2_q;
      end
      rxBit_q <= rxLvl_q ^ rxPol;
    end
  end

  // Transmit pin: a receiver only drives in ACK or an error flag
  always_comb begin
    txLevel = RECESSIVE;
    if (enable && (txActive || ackSlot || errFlagActive)) begin
      txLevel = txBit;
    end
    busTx_d = txLevel ^ txPol;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busTx_q <= RECESSIVE;
    end else begin
      busTx_q <= busTx_d;
    end
  end

  // Field tracking and bit position down-counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      curField_q <= FLD_IDLE;
      bitPos_q   <= 6'h00;
    end else if (fieldSeg.start) begin
      curField_q <= fieldSeg.code;
      bitPos_q   <= 6'(fieldSeg.len - 7'd1);
    end else if (bitTick) begin
      bitPos_q <= bitPos_q - 6'd1;
    end
  end

  // Snapshot of the most recent error only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      diag_q <= DIAG_RST;
    end else if (fault.hit) begin
      diag_q.rsv    <= 1'b0;
      diag_q.field  <= curField_q;
      diag_q.bitPos <= bitPos_q;
      diag_q.was_transmitter_flag    <= txActive;
      diag_q.stuff  <= fault.stuff;
      diag_q.crc    <= fault.crc;
      diag_q.mon    <= rxLvl_q;
      diag_q.drive  <= busTx_q;
    end
  end

  // Bit timer; buffer 0 clear beats the increment
  assign buf0Clear = tsEn && xferDone && xferBuf == 4'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tmr_q <= TMR_RST;
    end else if (buf0Clear) begin
      tmr_q <= TMR_RST;
    end else if (bitTick) begin
      tmr_q <= tmr_q + 16'h0001;
    end
  end

  // Stamp taken before any buffer 0 clear lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stamp_q    <= TMR_RST;
      stampVld_q <= 1'b0;
      stampBuf_q <= 4'h0;
    end else begin
      stampVld_q <= xferDone;
      if (xferDone) begin
        stamp_q    <= tmr_q;
        stampBuf_q <= xferBuf;
      end
    end
  end

  assign regRdData       = rdData_q;
  assign busTxPin        = busTx_q;
  assign rxBit           = rxBit_q;
  assign ctrlEnable      = enable;
  assign faultIrqPending = pend_q;
  assign stampValue      = stamp_q;
  assign stampValid      = stampVld_q;
  assign stampBuf        = stampBuf_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  ecnt_rx_read_a: assert property (
    regRd && regAddr == OFF_ECNT |=> regRdData[15:8] == $past(rxFaultTally))
    else $error("receive tally not in upper byte");

  ecnt_tx_read_a: assert property (
    regRd && regAddr == OFF_ECNT |=> regRdData[7:0] == $past(txFaultTally))
    else $error("transmit tally not in lower byte");

  diag_reset_a: assert property (
    $fell(rst) |-> diag_q == DIAG_RST && !diag_q.rsv)
    else $error("diagnostic not cleared by reset");

  diag_field_a: assert property (
    fieldSeg.start ##1 !fieldSeg.start ##1 fault.hit && !fieldSeg.start
      |=> diag_q.field == $past(fieldSeg.code, 3))
    else $error("field code not captured");

  bitpos_load_a: assert property (
    fieldSeg.start ##1 bitTick && !fieldSeg.start |=> bitPos_q == 6'($past(fieldSeg.len, 2) - 7'd2))
    else $error("bit position load or decrement wrong");

  diag_role_a: assert property (
    fault.hit |=> diag_q.was_transmitter_flag == $past(txActive) && diag_q.stuff == $past(fault.stuff))
    else $error("role or stuff flag not captured");

  diag_crc_a: assert property (
    fault.hit |=> diag_q.crc == $past(fault.crc))
    else $error("checksum flag not captured");

  diag_pins_a: assert property (
    fault.hit |=> diag_q.mon == $past(rxLvl_q) && diag_q.drive == $past(busTxPin))
    else $error("pin levels not captured");

  rx_quiet_a: assert property (
    !txActive && !ackSlot && !errFlagActive |=> busTxPin != $past(txPol))
    else $error("receiver drove the bus");

  tmr_count_a: assert property (
    bitTick && !buf0Clear |=> tmr_q == 16'($past(tmr_q) + 16'h0001))
    else $error("timer did not advance");

  tmr_clear_a: assert property (
    buf0Clear |=> tmr_q == TMR_RST)
    else $error("timer not cleared by buffer 0");

  stamp_take_a: assert property (
    xferDone |=> stampValid && stampValue == $past(tmr_q) && stampBuf == $past(xferBuf))
    else $error("time stamp wrong");

  pend_hold_a: assert property (
    tallyMoved |=> faultIrqPending ##1 (faultIrqPending || $past(clrPend)))
    else $error("pending flag lost");

  cfg_keep_a: assert property (
    !(regWr && regAddr == OFF_CFG) |=> $stable(cfg_q))
    else $error("configuration changed without write");

  tmr_wrap_a: assert property (
    tmr_q == 16'hFFFF && bitTick && !buf0Clear |=> tmr_q == 16'h0000)
    else $error("timer did not wrap");

  diag_read_a: assert property (
    regRd && regAddr == OFF_DIAG |=> regRdData == $past(diag_q))
    else $error("diagnostic read wrong");

  diag_hold_a: assert property (
    !fault.hit |=> $stable(diag_q))
    else $error("diagnostic changed without error");

  bitpos_tick_a: assert property (
    bitTick && !fieldSeg.start |=> bitPos_q == $past(bitPos_q) - 6'd1)
    else $error("bit position did not decrement");

  tmr_read_a: assert property (
    regRd && regAddr == OFF_TMR |=> regRdData == $past(tmr_q))
    else $error("timer read wrong");

  tmr_idle_a: assert property (
    !bitTick && !buf0Clear |=> $stable(tmr_q))
    else $error("timer moved without a bit");

  tx_drive_a: assert property (
    enable && txActive |=> busTxPin == ($past(txBit) ^ $past(txPol)))
    else $error("transmit level or polarity wrong");

  ack_drive_a: assert property (
    enable && (ackSlot || errFlagActive) |=> busTxPin == ($past(txBit) ^ $past(txPol)))
    else $error("receiver did not drive in its slot");

  rx_pol_a: assert property (
    1'b1 |=> rxBit == ($past(rxLvl_q) ^ $past(rxPol)))
    else $error("receive polarity wrong");

  pend_clr_a: assert property (
    clrPend && !tallyMoved |=> !faultIrqPending)
    else $error("pending flag not cleared");

  error_seen_c:  cover property (fault.hit && txActive);
  stuff_seen_c:  cover property (fault.hit && fault.stuff);
  rx_crc_c:      cover property (fault.hit && fault.crc && !txActive);
  stamp_clr_c:   cover property (buf0Clear ##1 bitTick);
  pend_clear_c:  cover property (faultIrqPending ##1 clrPend ##1 !faultIrqPending);

endmodule : ced_error_diag

`default_nettype wire

//--- src/ced_pkg.sv
// Shared constants and types for the CAN error diagnostic block
package ced_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFF_CFG  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ECNT = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_DIAG = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_TMR  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_IPND = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_ICLR = 4'h5;

  // Global configuration and interrupt clear bit positions
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_TXPOL_BIT = 1;
  localparam int CFG_RXPOL_BIT = 2;
  localparam int CFG_TSEN_BIT  = 3;
  localparam int CFG_USED      = 4;
  localparam int ICLR_BIT      = 0;

  // Reset values
  localparam logic [DATA_W-1:0] CFG_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] DIAG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TMR_RST  = 16'h0000;
  localparam logic [7:0]        TALLY_RST = 8'h00;
  localparam logic              RECESSIVE = 1'b1;

  // Frame field codes, ascending from zero
  typedef enum logic [3:0] {
    FLD_ERROR = 4'h0, FLD_ERR_DEL = 4'h1, FLD_ERR_ECHO = 4'h2,
    FLD_IDLE  = 4'h3, FLD_ACK     = 4'h4, FLD_EOF      = 4'h5,
    FLD_INTER = 4'h6, FLD_SUSPEND = 4'h7, FLD_SOF      = 4'h8,
    FLD_ARB   = 4'h9, FLD_IDE     = 4'hA, FLD_EXT_ARB  = 4'hB,
    FLD_RSV   = 4'hC, FLD_DLC     = 4'hD, FLD_DATA     = 4'hE,
    FLD_CRC   = 4'hF
  } ced_fcode_t;

  // Field start from the protocol engine
  typedef struct packed {
    logic       start;
    ced_fcode_t code;
    logic [6:0] len;
  } ced_fseg_t;

  // Error event from the protocol engine
  typedef struct packed {
    logic hit;
    logic stuff;
    logic crc;
  } ced_fault_t;

  // Diagnostic register layout
  typedef struct packed {
    logic       rsv;
    logic       drive;
    logic       mon;
    logic       crc;
    logic       stuff;
    logic       was_transmitter_flag;
    logic [5:0] bitPos;
    ced_fcode_t field;
  } ced_diag_t;

endpackage : ced_pkg

//--- verif/ced_error_diag_test.sv
// Self-checking bench for the error diagnostic block
`timescale 1ns/1ps
`default_nettype none

module ced_error_diag_test;
  import ced_pkg::*;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic [ADDR_W-1:0]  regAddr = '0;
  logic [DATA_W-1:0]  regWrData = '0;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [DATA_W-1:0]  regRdData;
  logic               busRxPin;
  logic               busTxPin;
  logic               bitTick = 1'b0;
  logic               txActive = 1'b0;
  logic               txBit = 1'b1;
  logic               ackSlot = 1'b0;
  logic               errFlagActive = 1'b0;
  logic [7:0]         rxTally = 8'h00;
  logic [7:0]         txTally = 8'h00;
  ced_fseg_t          fieldSeg = '0;
  ced_fault_t         fault = '0;
  logic               xferDone = 1'b0;
  logic [3:0]         xferBuf = 4'h0;
  logic               otherDom = 1'b0;
  logic               pend;
  logic [15:0]        stampValue;
  logic               stampValid;
  logic [3:0]         stampBuf;
  logic               rxBit;
  logic               ctrlEn;
  int                 nMismatch = 0;
  int                 checked = 0;

  ced_error_diag i_ced_error_diag (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .busRxPin(busRxPin), .busTxPin(busTxPin), .bitTick(bitTick), .txActive(txActive),
    .txBit(txBit), .ackSlot(ackSlot), .errFlagActive(errFlagActive),
    .rxFaultTally(rxTally), .txFaultTally(txTally), .fieldSeg(fieldSeg), .fault(fault),
    .xferDone(xferDone), .xferBuf(xferBuf), .rxBit(rxBit), .ctrlEnable(ctrlEn),
    .faultIrqPending(pend), .stampValue(stampValue), .stampValid(stampValid),
    .stampBuf(stampBuf));
  ced_xcvr_model i_ced_xcvr_model (.txPin(busTxPin), .otherDom(otherDom), .rxPin(busRxPin));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", nMismatch, checked);
    if (nMismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 cmp(regRdData, exp);
  endtask : rdc

  task automatic tick(input int n);
    @(posedge core_clk);
    bitTick <= 1'b1;
    cyc(n);
    bitTick <= 1'b0;
  endtask : tick

  // Field start, one bit, then the error: position is len minus two
  task automatic ev(input logic [3:0] c, input logic [6:0] len, input logic st, input logic cr);
    @(posedge core_clk);
    fieldSeg <= '{1'b1, ced_fcode_t'(c), len};
    @(posedge core_clk);
    fieldSeg.start <= 1'b0;
    bitTick <= 1'b1;
    @(posedge core_clk);
    bitTick <= 1'b0;
    fault <= '{1'b1, st, cr};
    @(posedge core_clk);
    fault <= '0;
  endtask : ev

  task automatic xfer(input logic [3:0] b, input logic [15:0] stamp);
    @(posedge core_clk);
    xferDone <= 1'b1;
    xferBuf <= b;
    @(posedge core_clk);
    xferDone <= 1'b0;
    #1 cmp({stampValid, 11'h000, stampBuf}, {1'b1, 11'h000, b});
    cmp(stampValue, stamp);
  endtask : xfer

  task automatic t_reset;
    rdc(OFF_ECNT, 16'h0000);
    rdc(OFF_DIAG, 16'h0000);
    rdc(OFF_TMR, 16'h0000);
    rdc(4'hF, 16'h0000);
  endtask : t_reset

  task automatic t_tally;
    @(posedge core_clk);
    rxTally <= 8'h12;
    txTally <= 8'h34;
    cyc(2);
    #1 cmp({15'h0000, pend}, 16'h0001);
    wr(OFF_ECNT, 16'hFFFF);
    rdc(OFF_ECNT, 16'h1234);
    wr(OFF_ICLR, 16'h0001);
    #1 cmp({15'h0000, pend}, 16'h0000);
  endtask : t_tally

  task automatic t_pins;
    int i;
    wr(OFF_CFG, 16'h0001);
    #1 cmp({15'h0000, ctrlEn}, 16'h0001);
    // Other node pulls the bus dominant: filtered level then polarity
    @(posedge core_clk);
    otherDom <= 1'b1;
    cyc(6);
    #1 cmp({15'h0000, rxBit}, 16'h0000);
    wr(OFF_CFG, 16'h0005);
    cyc(2);
    #1 cmp({15'h0000, rxBit}, 16'h0001);
    @(posedge core_clk);
    otherDom <= 1'b0;
    wr(OFF_CFG, 16'h0001);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      txBit <= 1'b0;
      ackSlot <= i[0];
      errFlagActive <= i[1];
      cyc(2);
      #1 cmp({15'h0000, busTxPin}, (i == 0) ? 16'h0001 : 16'h0000);
    end
    @(posedge core_clk);
    {ackSlot, errFlagActive, txBit} <= 3'b001;
    wr(OFF_CFG, 16'h0003);
    cyc(2);
    #1 cmp({15'h0000, busTxPin}, 16'h0000);
    rdc(OFF_CFG, 16'h0003);
    // Disable for power save: the rest of the setup must survive
    wr(OFF_CFG, 16'h0002);
    cyc(8);
    rdc(OFF_CFG, 16'h0002);
    cmp({15'h0000, ctrlEn}, 16'h0000);
    wr(OFF_CFG, 16'h0001);
    cyc(8);
  endtask : t_pins

  task automatic t_fields;
    int c;
    ced_diag_t d;
    for (c = 0; c < 16; c++) begin
      ev(c[3:0], 7'd8, c[1], c[0]);
      d = '{1'b0, 1'b1, 1'b1, c[0], c[1], 1'b0, 6'd6, ced_fcode_t'(c[3:0])};
      rdc(OFF_DIAG, d);
    end
    // Transmitting dominant: both pin snapshots must read 0
    @(posedge core_clk);
    txActive <= 1'b1;
    txBit <= 1'b0;
    cyc(10);
    ev(4'hE, 7'd64, 1'b1, 1'b0);
    d = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 6'd62, FLD_DATA};
    rdc(OFF_DIAG, d);
    @(posedge core_clk);
    txActive <= 1'b0;
    txBit <= 1'b1;
    cyc(8);
  endtask : t_fields

  task automatic t_timer;
    wr(OFF_CFG, 16'h0009);
    xfer(4'h3, 16'h0011);
    xfer(4'h0, 16'h0011);
    tick(5);
    rdc(OFF_TMR, 16'h0005);
    xfer(4'h3, 16'h0005);
    rdc(OFF_TMR, 16'h0005);
    xfer(4'h0, 16'h0005);
    rdc(OFF_TMR, 16'h0000);
    // Full lap plus one: wrap must be silent and keep counting
    tick(65537);
    rdc(OFF_TMR, 16'h0001);
    wr(OFF_CFG, 16'h0001);
    xfer(4'h0, 16'h0001);
    rdc(OFF_TMR, 16'h0001);
  endtask : t_timer

  initial begin
    cyc(16);
    rst <= 1'b0;
    t_reset();
    t_tally();
    t_pins();
    t_fields();
    t_timer();
    end_of_test();
  end

  initial begin
    #720us;
    nMismatch++;
    end_of_test();
  end
endmodule : ced_error_diag_test

`default_nettype wire

//--- verif/ced_xcvr_model.sv
// Transceiver model: wired bus seen back on the receive pin
`timescale 1ns/1ps
`default_nettype none

module ced_xcvr_model (
  input  wire logic txPin,
  input  wire logic otherDom,
  output logic      rxPin
);
  // Dominant 0 from either node wins; idle bus is recessive
  assign rxPin = txPin & ~otherDom;
endmodule : ced_xcvr_model

`default_nettype wire
